// *** ampc_top.sv ***
// Mode, standby, mute, diagnostic and register control of the four-channel amplifier
//
// Local design decisions: the register offsets and the APB register port.
`timescale 1ns/1ns
module ampc_top #(
   parameter int unsigned RETRY_CYC = ampc_pkg::RETRY_CYC, // Short retry interval
   parameter int unsigned MUTE_CYC = ampc_pkg::MUTE_CYC, // Soft mute duration
   parameter int unsigned QUAL_CYC = ampc_pkg::QUAL_CYC // Overcurrent qualify delay
) (
   input wire logic clk, // 20 MHz clock
   input wire logic rst_n, // Synchronous reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [7:0] paddr, // APB byte address
   input wire logic [31:0] pwdata, // APB write data
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error on unmapped address
   input wire logic address_select_pin_gnd, // Address select tied to ground
   input wire logic stb_mid, // Standby pin above standby level
   input wire logic stb_high, // Standby pin at operating level
   input wire logic vp_reset_low, // Supply below reset level
   input wire logic low_batt, // Low battery comparator
   input wire logic over_volt, // Overvoltage comparator
   input wire logic temp_warn, // Thermal pre-warning
   input wire logic svr_final, // Output within final step of target
   input wire logic [3:0] sc_gnd, // Short to ground per channel
   input wire logic [3:0] sc_vp, // Short to supply per channel
   input wire logic [3:0] sc_load, // Short across load per channel
   input wire logic [3:0] vo_low, // Output below 1 V
   input wire logic [3:0] i_gt4, // Load current above 4 A
   input wire logic [3:0] i_gt8, // Load current above 8 A
   input wire logic [3:0] vo_small, // Output below 1.75 V
   input wire logic [3:0] imiss_gt1, // Missing current above 1 A
   input wire logic [3:0] imiss_gt3, // Missing current above 3 A
   input wire logic [3:0] clip_2, // Distortion above 2 %
   input wire logic [3:0] clip_5, // Distortion above 5 %
   input wire logic [3:0] clip_10, // Distortion above 10 %
   output logic diagnostic_output_pin_o, // Diagnostic pin drive level
   output logic diagnostic_output_pin_oe_n, // Diagnostic pin pull, active low
   output logic standby_control_pin_o, // Standby pin drive level
   output logic standby_control_pin_oe_n, // Standby pin clip pull, active low
   output logic amp_on, // Amplifier powered
   output logic [3:0] ch_enable, // Channel output stage on
   output logic soft_mute_front, // Soft mute channels 1 and 3
   output logic soft_mute_rear, // Soft mute channels 2 and 4
   output logic fast_mute, // Fast mute all channels
   output logic mute_ramp, // Soft mute transition running
   output logic slow_ramp // Low-pop output ramp
);
   localparam int W = ampc_pkg::CNT_W;
   localparam int N = ampc_pkg::NCH;
   typedef struct packed {
      ampc_pkg::ampc_state_t state;
      logic [W-1:0] tmr;
      logic [W-1:0] mtmr;
      logic start;
      logic [5:0] mode;
      logic [15:0] cfg;
      logic por;
      logic stb_prev;
      logic amp;
      logic sm_f;
      logic sm_r;
      logic fm;
      logic slow;
      logic diagnostic_output_pin;
      logic stbo;
      logic [31:0] rdata;
      logic err;
   } ampc_top_t;
   ampc_top_t s;
   ampc_top_t next_s;

   function automatic logic ampc_mapped(input logic [7:0] a);
      return (a == ampc_pkg::A_START) | (a == ampc_pkg::A_MODE)
         | (a == ampc_pkg::A_CFG) | (a == ampc_pkg::A_STAT);
   endfunction

   function automatic logic ampc_clip(input logic [1:0] sel, input logic c2,
      input logic c5, input logic c10);
      case (sel)
         ampc_pkg::CLIP_2: ampc_clip = c2;
         ampc_pkg::CLIP_5: ampc_clip = c5;
         default: ampc_clip = c10;
      endcase
   endfunction

   // Every pin level is synchronised before any logic looks at it
   logic [ampc_pkg::SYNC_W-1:0] raw;
   logic [ampc_pkg::SYNC_W-1:0] y;
   logic legacy;
   logic y_stb_mid;
   logic y_stb_high;
   logic y_vp_low;
   logic y_lowb;
   logic y_ovv;
   logic y_temp;
   logic y_svr;
   logic [3:0] y_gnd;
   logic [3:0] y_vp;
   logic [3:0] y_load;
   logic [3:0] y_vlow;
   logic [3:0] y_i4;
   logic [3:0] y_i8;
   logic [3:0] y_vsm;
   logic [3:0] y_im1;
   logic [3:0] y_im3;
   logic [3:0] y_c2;
   logic [3:0] y_c5;
   logic [3:0] y_c10;

   assign raw = {address_select_pin_gnd, stb_mid, stb_high, vp_reset_low, low_batt,
      over_volt, temp_warn, svr_final, sc_gnd, sc_vp, sc_load, vo_low, i_gt4, i_gt8,
      vo_small, imiss_gt1, imiss_gt3, clip_2, clip_5, clip_10};
   assign {legacy, y_stb_mid, y_stb_high, y_vp_low, y_lowb, y_ovv, y_temp, y_svr,
      y_gnd, y_vp, y_load, y_vlow, y_i4, y_i8, y_vsm, y_im1, y_im3,
      y_c2, y_c5, y_c10} = y;

   ampc_sync #(
      .W(ampc_pkg::SYNC_W)
   ) u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .d(raw),
      .q(y)
   );

   logic [3:0] ch_on;
   logic [3:0] ch_fault;
   logic [15:0] ftypes;
   logic [3:0] clip;
   logic [3:0] clip_en;
   logic [3:0] route;
   logic [3:0] clip_diagnostic_output_pin;
   logic [3:0] clip_stb;

   assign clip_en = s.cfg[ampc_pkg::C_CLIPEN +: 4];
   assign route = s.cfg[ampc_pkg::C_ROUTE +: 4];

   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_ch
         ampc_ch_if cif ();
         assign cif.run = s.amp;
         assign cif.dis = s.cfg[ampc_pkg::C_CHDIS + g];
         assign cif.sc_gnd = y_gnd[g];
         assign cif.sc_vp = y_vp[g];
         assign cif.sc_load = y_load[g];
         assign cif.vo_low = y_vlow[g];
         assign cif.i_gt4 = y_i4[g];
         assign cif.i_gt8 = y_i8[g];
         assign cif.vo_small = y_vsm[g];
         assign cif.im_lo = y_im1[g];
         assign cif.im_hi = y_im3[g];
         assign ch_on[g] = cif.on;
         assign ch_fault[g] = cif.fault;
         assign ftypes[4*g +: 4] = cif.ftype;
         // Legacy mode has no threshold latch and uses the lowest level
         assign clip[g] = legacy ? y_c2[g]
            : ampc_clip(s.cfg[ampc_pkg::C_CLIPSEL +: 2], y_c2[g], y_c5[g], y_c10[g]);
         ampc_chprot #(
            .RETRY_CYC(RETRY_CYC),
            .QUAL_CYC(QUAL_CYC)
         ) u_prot (
            .clk(clk),
            .rst_n(rst_n),
            .c(cif)
         );
      end
   endgenerate

   assign clip_stb = legacy ? 4'h0 : (clip & clip_en & route);
   assign clip_diagnostic_output_pin = legacy ? clip : (clip & clip_en & ~route);

   logic por_ev;
   logic go;
   logic req_f;
   logic req_r;
   logic req_fast;
   logic fault_any;
   logic temp_rep;
   logic lf_rep;
   logic wr;
   logic [31:0] stat;

   // In bus mode the mid comparator is the two-level standby threshold
   assign por_ev = ~legacy & ((y_stb_mid & ~s.stb_prev) | y_vp_low);
   assign go = legacy ? y_stb_mid : (s.start & y_stb_mid & ~s.por);
   assign req_f = legacy ? ~y_stb_high : s.mode[ampc_pkg::M_FRONT];
   assign req_r = legacy ? ~y_stb_high : s.mode[ampc_pkg::M_REAR];
   assign req_fast = ~legacy & s.mode[ampc_pkg::M_FAST];
   assign fault_any = |ch_fault;
   // Disabling a report gates only the pin; status reads stay live
   assign temp_rep = legacy | ~s.mode[ampc_pkg::M_TEMP_DIS];
   assign lf_rep = legacy | ~s.mode[ampc_pkg::M_LF_DIS];
   assign wr = psel & penable & pwrite;
   assign stat = {ftypes, ch_on, clip, s.por, y_temp, y_lowb, fault_any, s.sm_f | s.sm_r
      | s.fm ? s.mtmr != '0 : 1'b0, legacy, s.state};

   always_comb begin
      next_s = s;
      next_s.stb_prev = y_stb_mid;
      case (s.state)
         ampc_pkg::ST_OFF: begin
            if (go) begin
               next_s.state = ampc_pkg::ST_RAMP;
            end
         end
         ampc_pkg::ST_RAMP: begin
            if (!go) begin
               next_s.state = ampc_pkg::ST_OFF;
            end else if (y_svr) begin
               next_s.state = ampc_pkg::ST_RUN;
            end
         end
         ampc_pkg::ST_RUN: begin
            if (!go) begin
               next_s.state = ampc_pkg::ST_FMUTE;
               next_s.tmr = W'(ampc_pkg::FMUTE_CYC - 1);
            end
         end
         ampc_pkg::ST_FMUTE: begin
            if (s.tmr == '0) begin
               next_s.state = ampc_pkg::ST_OFF;
            end else begin
               next_s.tmr = s.tmr - 1'b1;
            end
         end
         default: next_s.state = ampc_pkg::ST_OFF;
      endcase
      if (y_vp_low) begin
         next_s.state = ampc_pkg::ST_OFF;
      end
      next_s.amp = (s.state != ampc_pkg::ST_OFF);
      // Mute is held through start-up and released only from the run state
      next_s.sm_f = (s.state != ampc_pkg::ST_RUN) | req_f;
      next_s.sm_r = (s.state != ampc_pkg::ST_RUN) | req_r;
      next_s.fm = (s.state == ampc_pkg::ST_FMUTE)
         | ((s.state == ampc_pkg::ST_RUN) & req_fast);
      if ((next_s.sm_f != s.sm_f) | (next_s.sm_r != s.sm_r) | (s.fm & ~next_s.fm)) begin
         next_s.mtmr = W'(MUTE_CYC - 1);
      end else if (s.mtmr != '0) begin
         next_s.mtmr = s.mtmr - 1'b1;
      end
      next_s.slow = (s.state != ampc_pkg::ST_RUN) & ~s.mode[ampc_pkg::M_LOWPOP_DIS];
      if (wr) begin
         case (paddr)
            ampc_pkg::A_START: begin
               next_s.start = pwdata[0];
               if (pwdata[0]) begin
                  next_s.por = 1'b0;
               end
            end
            ampc_pkg::A_MODE: next_s.mode = pwdata[5:0];
            ampc_pkg::A_CFG: next_s.cfg = pwdata[15:0];
            default: next_s.err = 1'b0;
         endcase
      end
      // Power-on reset after the write so that it wins over a clear
      if (por_ev) begin
         next_s.por = 1'b1;
         next_s.start = 1'b0;
         next_s.mode = ampc_pkg::MODE_RST;
         next_s.cfg = ampc_pkg::CFG_RST;
      end
      next_s.diagnostic_output_pin = (~legacy & s.por) | y_lowb | y_ovv | (temp_rep & y_temp)
         | (lf_rep & fault_any) | (|clip_diagnostic_output_pin);
      next_s.stbo = |clip_stb;
      if (psel & ~penable) begin
         next_s.err = ~ampc_mapped(paddr);
         case (paddr)
            ampc_pkg::A_START: next_s.rdata = 32'(s.start);
            ampc_pkg::A_MODE: next_s.rdata = 32'(s.mode);
            ampc_pkg::A_CFG: next_s.rdata = 32'(s.cfg);
            ampc_pkg::A_STAT: next_s.rdata = stat;
            default: next_s.rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s <= '0;
         s.mode <= ampc_pkg::MODE_RST;
         s.cfg <= ampc_pkg::CFG_RST;
      end else begin
         s <= next_s;
      end
   end

   assign prdata = s.rdata;
   assign pready = 1'b1;
   assign pslverr = psel & penable & s.err;
   assign diagnostic_output_pin_o = 1'b0;
   assign diagnostic_output_pin_oe_n = ~s.diagnostic_output_pin;
   assign standby_control_pin_o = 1'b0;
   assign standby_control_pin_oe_n = ~s.stbo;
   assign amp_on = s.amp;
   assign ch_enable = ch_on;
   assign soft_mute_front = s.sm_f;
   assign soft_mute_rear = s.sm_r;
   assign fast_mute = s.fm;
   assign mute_ramp = (s.mtmr != '0);
   assign slow_ramp = s.slow;
endmodule

// *** ampc_pkg.sv ***
// Constants, register map and types of the amplifier protection and mode control
package ampc_pkg;
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam int unsigned CLK_KHZ = CLK_HZ / 1000;
   localparam int unsigned RETRY_MS = 16;
   localparam int unsigned MUTE_MS = 20;
   localparam int unsigned QUAL_US = 300;
   localparam int unsigned MISS_US = 80;
   localparam int unsigned FMUTE_US = 100;
   localparam int unsigned RETRY_CYC = RETRY_MS * CLK_KHZ;
   localparam int unsigned MUTE_CYC = MUTE_MS * CLK_KHZ;
   localparam int unsigned QUAL_CYC = (QUAL_US * CLK_KHZ + 999) / 1000;
   localparam int unsigned MISS_CYC = (MISS_US * CLK_KHZ + 999) / 1000;
   localparam int unsigned FMUTE_CYC = (FMUTE_US * CLK_KHZ) / 1000;
   localparam int CNT_W = 19;
   localparam int NCH = 4;
   localparam int SYNC_W = 56;
   // Register byte addresses
   localparam logic [7:0] A_START = 8'h00;
   localparam logic [7:0] A_MODE = 8'h04;
   localparam logic [7:0] A_CFG = 8'h08;
   localparam logic [7:0] A_STAT = 8'h0C;
   // Mode register fields
   localparam int M_FRONT = 0;
   localparam int M_REAR = 1;
   localparam int M_FAST = 2;
   localparam int M_LOWPOP_DIS = 3;
   localparam int M_LF_DIS = 4;
   localparam int M_TEMP_DIS = 5;
   localparam logic [5:0] MODE_RST = 6'h00;
   // Configuration register fields
   localparam int C_CLIPSEL = 0;
   localparam int C_ROUTE = 4;
   localparam int C_CHDIS = 8;
   localparam int C_CLIPEN = 12;
   localparam logic [15:0] CFG_RST = 16'h0000;
   // Fault type bits per channel
   localparam int FT_GND = 0;
   localparam int FT_VP = 1;
   localparam int FT_LOAD = 2;
   localparam int FT_OC = 3;
   typedef enum logic [1:0] {CLIP_2, CLIP_5, CLIP_10} ampc_clip_t;
   typedef enum logic [1:0] {ST_OFF, ST_RAMP, ST_RUN, ST_FMUTE} ampc_state_t;
endpackage

// *** ampc_ch_if.sv ***
// Link between the controller and one channel's protection logic
`timescale 1ns/1ns
interface ampc_ch_if;
   logic run;
   logic dis;
   logic sc_gnd;
   logic sc_vp;
   logic sc_load;
   logic vo_low;
   logic i_gt4;
   logic i_gt8;
   logic vo_small;
   logic im_lo;
   logic im_hi;
   logic on;
   logic fault;
   logic [3:0] ftype;
   modport ctl (output run, dis, sc_gnd, sc_vp, sc_load, vo_low, i_gt4, i_gt8,
      vo_small, im_lo, im_hi, input on, fault, ftype);
   modport prot (input run, dis, sc_gnd, sc_vp, sc_load, vo_low, i_gt4, i_gt8,
      vo_small, im_lo, im_hi, output on, fault, ftype);
endinterface

// *** ampc_sync.sv ***
// Two-flop synchroniser for a bus of independent levels
`timescale 1ns/1ns
module ampc_sync #(
   parameter int W = 8 // Bus width
) (
   input wire logic clk, // Clock
   input wire logic rst_n, // Synchronous reset, active low
   input wire logic [W-1:0] d, // Asynchronous levels
   output logic [W-1:0] q // Synchronised levels
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } ampc_sync_t;
   ampc_sync_t s;
   ampc_sync_t next_s;
   always_comb begin
      next_s.meta = d;
      next_s.stable = s.meta;
   end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
   assign q = s.stable;
endmodule

// *** ampc_chprot.sv ***
// Short, safe-operating-area and missing-current protection of one channel
`timescale 1ns/1ns
module ampc_chprot #(
   parameter int unsigned RETRY_CYC = ampc_pkg::RETRY_CYC, // Off time after a trip
   parameter int unsigned QUAL_CYC = ampc_pkg::QUAL_CYC // Low-voltage overcurrent delay
) (
   input wire logic clk, // Clock
   input wire logic rst_n, // Synchronous reset, active low
   ampc_ch_if.prot c // Channel link
);
   localparam int W = ampc_pkg::CNT_W;
   typedef struct packed {
      logic [W-1:0] retry;
      logic [W-1:0] qual;
      logic [W-1:0] miss;
      logic on;
      logic [3:0] ftype;
   } ampc_chst_t;
   ampc_chst_t s;
   ampc_chst_t next_s;
   logic short_any;
   logic soa_lo;
   logic soa_hi;
   logic miss_c;
   logic trip;
   assign short_any = c.sc_gnd | c.sc_vp | c.sc_load;
   assign soa_lo = c.vo_low & c.i_gt4;
   assign soa_hi = ~c.vo_low & c.i_gt8;
   assign miss_c = c.vo_small ? c.im_lo : c.im_hi;
   // Only a live channel can trip; comparators are meaningless while it is off
   assign trip = s.on & (short_any
      | soa_hi
      | (soa_lo & (s.qual == W'(QUAL_CYC)))
      | (miss_c & (s.miss == W'(ampc_pkg::MISS_CYC - 1))));
   always_comb begin
      next_s = s;
      next_s.qual = (s.on & soa_lo) ? s.qual + 1'b1 : '0;
      next_s.miss = (s.on & miss_c) ? s.miss + 1'b1 : '0;
      if (s.retry != '0) begin
         next_s.retry = s.retry - 1'b1;
      end
      if (trip) begin
         next_s.retry = W'(RETRY_CYC - 1);
         next_s.ftype[ampc_pkg::FT_GND] = c.sc_gnd;
         next_s.ftype[ampc_pkg::FT_VP] = c.sc_vp;
         next_s.ftype[ampc_pkg::FT_LOAD] = c.sc_load;
         next_s.ftype[ampc_pkg::FT_OC] = soa_lo | soa_hi | miss_c;
      end
      // Retry restores the channel; a kept short or soa_hi fault trips it again next cycle
      next_s.on = c.run & ~c.dis & ~trip & (next_s.retry == '0);
   end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
   assign c.on = s.on;
   assign c.fault = (s.retry != '0);
   assign c.ftype = s.ftype;
endmodule

// *** ampc_checker.sv ***
// Port-level assertions for the amplifier mode and protection control
`timescale 1ns/1ns
module ampc_checker (
   input wire logic clk, // Clock
   input wire logic rst_n, // Reset, active low
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic [7:0] paddr, // APB address
   input wire logic pslverr, // APB error
   input wire logic address_select_pin_gnd, // Legacy select
   input wire logic stb_mid, // Standby level
   input wire logic vp_reset_low, // Supply low
   input wire logic diagnostic_output_pin_o, // Diagnostic_output_pin level
   input wire logic diagnostic_output_pin_oe_n, // Diagnostic_output_pin pull
   input wire logic standby_control_pin_o, // Standby pin level
   input wire logic amp_on, // Amplifier on
   input wire logic [3:0] ch_enable, // Channels on
   input wire logic soft_mute_front, // Front mute
   input wire logic soft_mute_rear, // Rear mute
   input wire logic fast_mute // Fast mute
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   localparam int FM_LO = ampc_pkg::FMUTE_CYC - 100;
   localparam int FM_HI = ampc_pkg::FMUTE_CYC + 100;
   // Shutdown fast mute is timed on a counter; a delay window that long is too slow to unroll
   logic [11:0] fm_cnt;
   always_ff @(posedge clk) begin
      if (!rst_n || !(fast_mute && amp_on && !stb_mid)) begin
         fm_cnt <= 12'h000;
      end else if (fm_cnt != 12'hFFF) begin
         fm_cnt <= fm_cnt + 12'h001;
      end
   end
   sequence s_fm_start;
      $rose(fast_mute) && !stb_mid;
   endsequence
   // Amplifier must stay on for the first 8 cycles of the fast mute
   sequence s_hold_on;
      amp_on [*8];
   endsequence
   a_err_unmapped: assert property (psel && penable && paddr > 8'h0C |-> pslverr)
      else $error("no error on unmapped address");
   a_ok_mapped: assert property (psel && penable && paddr inside {8'h00, 8'h04, 8'h08, 8'h0C}
      |-> !pslverr) else $error("error on mapped address");
   a_por_diagnostic_output_pin_low: assert property ($rose(stb_mid) && !address_select_pin_gnd
      |-> ##[1:6] !diagnostic_output_pin_oe_n) else $error("diagnostic_output_pin not pulled after standby rise");
   a_supply_off: assert property (vp_reset_low [*5] |-> !amp_on)
      else $error("amplifier on with low supply");
   a_stb_fast_mute: assert property (amp_on && !soft_mute_front && !soft_mute_rear
      && !fast_mute && $fell(stb_mid) |-> ##[1:5] fast_mute) else $error("no fast mute");
   a_fmute_then_off: assert property (s_fm_start |-> s_hold_on)
      else $error("shutdown timing after fast mute wrong");
   a_fmute_bound: assert property (fm_cnt <= FM_HI)
      else $error("amplifier not shut down after fast mute");
   a_fmute_length: assert property ($fell(amp_on) && $past(fast_mute) && !stb_mid
      |-> fm_cnt >= FM_LO) else $error("shutdown before fast mute finished");
   a_off_no_channel: assert property (!amp_on && !$past(amp_on) && !$past(amp_on, 2)
      |-> ch_enable == 4'h0) else $error("channel on while amplifier off");
   a_pin_pull_only: assert property (!diagnostic_output_pin_o && !standby_control_pin_o)
      else $error("pin drive level not low");
   a_off_muted: assert property ($past(rst_n, 2) && !amp_on && !$past(amp_on)
      |-> soft_mute_front && soft_mute_rear) else $error("unmuted while off");
endmodule
bind ampc_top ampc_checker ampc_checker_inst (.*);

// *** ampc_svr_model.sv ***
// Output settling model: reports the end of the start-up ramp
`timescale 1ns/1ns
module ampc_svr_model #(
   parameter int RAMP_CYC = 30 // Ramp length, arbitrary
) (
   input wire logic clk, // Clock
   input wire logic amp_on, // Amplifier powered
   output logic svr_final // Output within final step
);
   int cnt = 0;
   // Output collapses at once when the amplifier is off
   always @(posedge clk) begin
      cnt <= amp_on ? (cnt < RAMP_CYC ? cnt + 1 : cnt) : 0;
   end
   assign svr_final = (cnt >= RAMP_CYC);
endmodule

// *** ampc_top_bench.sv ***
// Register-level test sequence of the amplifier control block
`timescale 1ns/1ns
module ampc_top_bench;
   localparam int LIMIT = 20000;
   logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, d;
   logic address_select_pin_gnd = 0, stb_mid = 0, stb_high = 0, vp_reset_low = 0;
   logic low_batt = 0, over_volt = 0, temp_warn = 0, svr_final, dg;
   logic [3:0] sc_gnd = 4'h0, sc_vp = 4'h0, sc_load = 4'h0, vo_low = 4'h0, i_gt4 = 4'h0;
   logic [3:0] i_gt8 = 4'h0, vo_small = 4'h0, imiss_gt1 = 4'h0, imiss_gt3 = 4'h0;
   logic [3:0] clip_2 = 4'h0, clip_5 = 4'h0, clip_10 = 4'h0, ch_enable;
   logic diagnostic_output_pin_o, diagnostic_output_pin_oe_n, standby_control_pin_o;
   logic standby_control_pin_oe_n, amp_on, soft_mute_front, soft_mute_rear, fast_mute;
   logic mute_ramp, slow_ramp;
   int n_mismatch = 0, tests_run = 0, cyc = 0;
   assign dg = diagnostic_output_pin_oe_n;
   ampc_top #(.RETRY_CYC(50), .MUTE_CYC(40), .QUAL_CYC(20)) ampc_top_inst (.*);
   ampc_svr_model ampc_svr_model_inst (.clk(clk), .amp_on(amp_on), .svr_final(svr_final));
   always #25 clk = ~clk;
   task wrap_up;
      $display("Checks %0d, mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task chk(input bit ok);
      tests_run++;
      if (!ok) begin
         n_mismatch++;
         $display("MISMATCH at %0t: check %0d differs", $time, tests_run);
      end
   endtask
   task w(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Always entered just after a rising edge; holds the request until pready
   task xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      d = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         n_mismatch++;
         wrap_up;
      end
   end
   initial begin
      w(4);
      rst_n <= 1'b1;
      w(1);
      xfer(0, 8'h0C, 0);
      chk(d === 32'h0000_0008);
      xfer(0, 8'h04, 0);
      chk(d === 32'h0000_0000);
      xfer(0, 8'h10, 0);
      chk(e === 1'b1 && d === 32'h0000_0000);
      xfer(1, 8'h08, 32'h0000_FFFF);
      xfer(0, 8'h08, 0);
      chk(d === 32'h0000_FFFF);
      xfer(1, 8'h08, 0);
      stb_mid <= 1'b1;
      w(6);
      chk(dg === 1'b0);
      xfer(0, 8'h0C, 0);
      chk(d[7] === 1'b1);
      xfer(1, 8'h00, 32'h0000_0001);
      w(2);
      chk(dg === 1'b1);
      xfer(0, 8'h0C, 0);
      chk(d[7] === 1'b0 && amp_on === 1'b1 && slow_ramp === 1'b1);
      chk(soft_mute_front === 1'b1);
      w(40);
      chk(soft_mute_front === 1'b0 && soft_mute_rear === 1'b0 && ch_enable === 4'hF);
      chk(slow_ramp === 1'b0);
      xfer(1, 8'h04, 32'h0000_0006);
      w(2);
      chk(soft_mute_rear === 1'b1 && soft_mute_front === 1'b0 && mute_ramp === 1'b1);
      chk(fast_mute === 1'b1);
      xfer(1, 8'h04, 0);
      w(50);
      low_batt <= 1'b1;
      w(5);
      chk(dg === 1'b0);
      low_batt <= 1'b0;
      w(5);
      chk(dg === 1'b1);
      sc_gnd <= 4'h1;
      w(5);
      chk(ch_enable === 4'hE && dg === 1'b0);
      xfer(0, 8'h0C, 0);
      chk(d[19:16] === 4'h1);
      sc_gnd <= 4'h0;
      w(60);
      chk(ch_enable === 4'hF);
      xfer(1, 8'h04, 32'h0000_0010);
      sc_vp <= 4'h2;
      w(5);
      chk(ch_enable === 4'hD && dg === 1'b1);
      xfer(0, 8'h0C, 0);
      chk(d[23:20] === 4'h2);
      sc_vp <= 4'h0;
      xfer(1, 8'h04, 0);
      w(60);
      xfer(1, 8'h08, 32'h0000_0100);
      w(65);
      chk(ch_enable === 4'hE);
      xfer(1, 8'h08, 0);
      w(5);
      i_gt8 <= 4'h4;
      w(5);
      chk(ch_enable === 4'hB);
      i_gt8 <= 4'h0;
      w(60);
      vo_low <= 4'h8;
      i_gt4 <= 4'h8;
      w(12);
      chk(ch_enable === 4'hF);
      w(20);
      chk(ch_enable === 4'h7);
      vo_low <= 4'h0;
      i_gt4 <= 4'h0;
      w(60);
      vo_small <= 4'h1;
      imiss_gt1 <= 4'h1;
      w(1500);
      chk(ch_enable[0] === 1'b1);
      w(120);
      chk(ch_enable[0] === 1'b0);
      vo_small <= 4'h0;
      imiss_gt1 <= 4'h0;
      w(60);
      xfer(1, 8'h08, 32'h0000_8080);
      clip_2 <= 4'h8;
      w(5);
      chk(standby_control_pin_oe_n === 1'b0 && dg === 1'b1);
      xfer(1, 8'h08, 32'h0000_8081);
      w(5);
      chk(standby_control_pin_oe_n === 1'b1);
      clip_5 <= 4'h8;
      w(5);
      chk(standby_control_pin_oe_n === 1'b0);
      clip_2 <= 4'h0;
      clip_5 <= 4'h0;
      xfer(1, 8'h08, 0);
      stb_mid <= 1'b0;
      w(6);
      chk(fast_mute === 1'b1 && amp_on === 1'b1);
      w(2100);
      chk(amp_on === 1'b0);
      xfer(1, 8'h04, 32'h0000_0003);
      vp_reset_low <= 1'b1;
      w(6);
      chk(dg === 1'b0);
      xfer(0, 8'h04, 0);
      chk(d === 32'h0000_0000);
      xfer(0, 8'h0C, 0);
      chk(d[7] === 1'b1);
      vp_reset_low <= 1'b0;
      address_select_pin_gnd <= 1'b1;
      stb_mid <= 1'b1;
      stb_high <= 1'b1;
      w(60);
      chk(amp_on === 1'b1 && soft_mute_front === 1'b0);
      stb_high <= 1'b0;
      w(5);
      chk(soft_mute_front === 1'b1 && mute_ramp === 1'b1);
      vp_reset_low <= 1'b1;
      w(6);
      chk(amp_on === 1'b0 && dg === 1'b1);
      wrap_up;
   end
endmodule
